// file: hdl/prs_pkg.sv
// Package with constants and carriers for the 100Base-TX receive status bits
// ==========================================================================
package prs_pkg;

    // ======================================================================
    // Bit positions in the extended receive status register
    localparam int unsigned SIG_LOST_BIT  = 10;
    localparam int unsigned PLL_ERR_BIT   = 9;
    localparam int unsigned FALSE_CAR_BIT = 8;
    localparam int unsigned INV_SYM_BIT   = 7;
    localparam int unsigned HALT_BIT      = 6;
    localparam int unsigned PREM_END_BIT  = 5;
    localparam int unsigned ANEG_DONE_BIT = 4;
    localparam int unsigned SIG_DET_BIT   = 3;
    localparam int unsigned JABBER_BIT    = 2;
    localparam int unsigned RFAULT_BIT    = 1;
    localparam int unsigned LINK_BIT      = 0;

    // ======================================================================
    // Sizes and reset values
    localparam int unsigned REG_W       = 16;
    localparam int unsigned NUM_EVENTS  = 6;
    localparam int unsigned EVENT_LSB   = PREM_END_BIT;
    localparam logic [15:0] STATUS_RST  = 16'h0000;
    localparam logic [5:0]  EVENTS_RST  = 6'h00;
    localparam logic [1:0]  IDLE_RUN    = 2'h2;   // Idles in a row that end a packet early
    localparam logic [1:0]  IDLE_RST    = 2'h0;

    // ======================================================================
    // One decoded receive symbol from the 100Base-TX decoder
    typedef struct packed {
        logic sym_valid;   // A symbol is present this cycle
        logic in_packet;   // Symbol lies inside a valid packet
        logic invalid;     // Symbol code is not a legal code group
        logic halt;        // Symbol is a Halt
        logic idle;        // Symbol is an Idle
        logic jk_fail;     // Carrier start did not turn out to be /J/K/
    } prs_rx_sym_t;

    // Live levels from the rest of the PHY
    typedef struct packed {
        logic mode_100;      // One while 100Base-TX is selected
        logic sig_detect;    // Receive pair activity
        logic pll_fail;      // Receive PLL failed to lock
        logic aneg_enable;   // Control bit for auto-negotiation enable
        logic aneg_done;     // Negotiation process finished
        logic jabber;        // Basic status jabber bit
        logic remote_fault;  // Basic status remote fault bit
        logic link_ok;       // Basic status link bit
    } prs_phy_lvl_t;

endpackage

// file: hdl/prs_latch_bit.sv
// Latching-high status bit with set priority over a read clear
`timescale 1ns/100ps

module prs_latch_bit (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_q
);

    logic next_q;

    // ======================================================================
    // Set wins so an event coinciding with the read is kept for the next one
    always_comb begin
        next_q = i_set | (o_q & ~i_clr);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_q <= 1'b0;
        end else begin
            o_q <= next_q;
        end
    end

endmodule

// file: hdl/prs_rx_status.sv
// Extended receive status bits of a 10/100 PHY: event latches and live mirrors
`timescale 1ns/100ps

module prs_rx_status (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire prs_pkg::prs_rx_sym_t i_rx_sym,
    input  wire prs_pkg::prs_phy_lvl_t i_lvl,
    input  wire logic                 i_rd_strobe,
    output logic [15:0]               o_status,
    output logic                      o_rx_err
);

    // ======================================================================
    // Declarations
    logic [prs_pkg::NUM_EVENTS-1:0] ev_set;
    logic [prs_pkg::NUM_EVENTS-1:0] ev_q;
    logic [1:0]                     idle_cnt;
    logic [1:0]                     next_idle_cnt;
    logic                           next_rx_err;
    logic [15:0]                    next_status;
    logic                           sym_in_pkt;
    logic                           prem_end;

    // ======================================================================
    // Symbol classification inside a packet, 100Base mode only
    // Events are gated by the mode so 10Base-T activity cannot leave stale bits
    assign sym_in_pkt = i_lvl.mode_100 & i_rx_sym.sym_valid & i_rx_sym.in_packet;

    // Run length of Idle symbols inside the current packet
    always_comb begin
        next_idle_cnt = prs_pkg::IDLE_RST;
        if (sym_in_pkt && i_rx_sym.idle) begin
            if (idle_cnt < prs_pkg::IDLE_RUN) begin
                next_idle_cnt = idle_cnt + 2'h1;
            end else begin
                next_idle_cnt = idle_cnt;
            end
        end else if (i_rx_sym.in_packet && !i_rx_sym.sym_valid) begin
            next_idle_cnt = idle_cnt;   // No symbol this cycle, keep the run
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            idle_cnt <= prs_pkg::IDLE_RST;
        end else begin
            idle_cnt <= next_idle_cnt;
        end
    end

    // Every Idle that follows another Idle in the same packet marks a premature end.
    // The counter saturates, so a third Idle still counts as a second one in a row:
    // a read that lands between two Idles of a long run cannot hide the condition.
    assign prem_end = sym_in_pkt & i_rx_sym.idle & (idle_cnt >= prs_pkg::IDLE_RUN - 2'h1);

    // ======================================================================
    // Event sources, one per latched bit, low index = premature end
    // Signal lost is a level: while the pair stays quiet it re-latches after every read
    always_comb begin
        ev_set    = '0;
        ev_set[prs_pkg::PREM_END_BIT  - prs_pkg::EVENT_LSB] = prem_end;
        ev_set[prs_pkg::HALT_BIT      - prs_pkg::EVENT_LSB] = sym_in_pkt & i_rx_sym.halt;
        ev_set[prs_pkg::INV_SYM_BIT   - prs_pkg::EVENT_LSB] = sym_in_pkt & i_rx_sym.invalid;
        ev_set[prs_pkg::FALSE_CAR_BIT - prs_pkg::EVENT_LSB] = i_lvl.mode_100 & i_rx_sym.jk_fail;
        ev_set[prs_pkg::PLL_ERR_BIT   - prs_pkg::EVENT_LSB] = i_lvl.mode_100 & i_lvl.pll_fail;
        ev_set[prs_pkg::SIG_LOST_BIT  - prs_pkg::EVENT_LSB] = i_lvl.mode_100 & ~i_lvl.sig_detect;
    end

    // One latch per event bit; a read clears at once every bit whose event is not present in that cycle
    genvar gi;
    generate
        for (gi = 0; gi < prs_pkg::NUM_EVENTS; gi++) begin : g_ev
            prs_latch_bit u_bit (
                .i_mclk  (i_mclk),
                .i_rst_n (i_rst_n),
                .i_set   (ev_set[gi]),
                .i_clr   (i_rd_strobe),
                .o_q     (ev_q[gi])
            );

            // Per-bit latch behaviour, checked on every event bit alike
            a_bit_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                ev_set[gi]
                |=> ev_q[gi])
                else $error("Event did not latch its bit");
            a_bit_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                (ev_q[gi] && !i_rd_strobe)
                |=> ev_q[gi])
                else $error("Latched bit dropped without read");
            a_bit_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                (i_rd_strobe && !ev_set[gi])
                |=> !ev_q[gi])
                else $error("Read left a latched bit set");
            a_bit_image: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
                1'b1
                |=> o_status[prs_pkg::EVENT_LSB + gi] == $past(ev_q[gi]))
                else $error("Register image does not follow its latch");
        end
    endgenerate

    // ======================================================================
    // Receive error toward the MAC: bad symbol or Halt inside a packet
    // Registered, so the MAC sees it one edge after the symbol, in step with the latch
    always_comb begin
        next_rx_err = sym_in_pkt & (i_rx_sym.invalid | i_rx_sym.halt);
    end

    // ======================================================================
    // Register image; the read port sees the value registered a cycle earlier
    // Bits 15:11 belong to other logic and read as zero here
    // A read right after another read still sees the image from before the clear
    always_comb begin
        next_status = prs_pkg::STATUS_RST;
        next_status[prs_pkg::SIG_LOST_BIT:prs_pkg::PREM_END_BIT] = ev_q;
        next_status[prs_pkg::ANEG_DONE_BIT] = i_lvl.aneg_enable & i_lvl.aneg_done;
        next_status[prs_pkg::SIG_DET_BIT]   = i_lvl.sig_detect;
        next_status[prs_pkg::JABBER_BIT]    = i_lvl.jabber;
        next_status[prs_pkg::RFAULT_BIT]    = i_lvl.remote_fault;
        next_status[prs_pkg::LINK_BIT]      = i_lvl.link_ok;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_status <= prs_pkg::STATUS_RST;
            o_rx_err <= 1'b0;
        end else begin
            o_status <= next_status;
            o_rx_err <= next_rx_err;
        end
    end

    // ======================================================================
    // Checks
    // All checks rest while reset is held, except the one on the reset values;
    // each event shows in the image two edges after the edge that takes it
    a_sig_lost_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_lvl.mode_100 && !i_lvl.sig_detect) |-> ##2 o_status[prs_pkg::SIG_LOST_BIT])
        else $error("Signal lost not latched");
    a_pll_err_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_lvl.mode_100 && i_lvl.pll_fail) |-> ##2 o_status[prs_pkg::PLL_ERR_BIT])
        else $error("PLL lock error not latched");
    a_false_car_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_lvl.mode_100 && i_rx_sym.jk_fail) |-> ##2 o_status[prs_pkg::FALSE_CAR_BIT])
        else $error("False carrier not latched");
    a_rx_err_pulse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sym_in_pkt && i_rx_sym.invalid) |=> o_rx_err ##1 o_status[prs_pkg::INV_SYM_BIT])
        else $error("Invalid symbol not reported");
    a_halt_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sym_in_pkt && i_rx_sym.halt) |=> o_rx_err ##1 o_status[prs_pkg::HALT_BIT])
        else $error("Halt symbol not reported");
    a_prem_end_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sym_in_pkt && i_rx_sym.idle) ##1 (sym_in_pkt && i_rx_sym.idle) |-> ##2 o_status[prs_pkg::PREM_END_BIT])
        else $error("Premature end not latched");
    a_hold_till_rd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (ev_q[prs_pkg::HALT_BIT - prs_pkg::EVENT_LSB] && !i_rd_strobe)
        |=> ev_q[prs_pkg::HALT_BIT - prs_pkg::EVENT_LSB])
        else $error("Latched bit dropped without read");
    a_clear_on_rd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd_strobe && ev_set == '0) |=> ev_q == '0)
        else $error("Read did not clear latched bits");
    a_set_beats_rd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd_strobe && ev_set[prs_pkg::INV_SYM_BIT - prs_pkg::EVENT_LSB])
        |=> ##1 o_status[prs_pkg::INV_SYM_BIT])
        else $error("Event lost during read");
    a_ten_mode_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_lvl.mode_100 |-> ev_set == '0)
        else $error("Event raised in 10Base-T mode");
    a_aneg_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_status[prs_pkg::ANEG_DONE_BIT] == $past(i_lvl.aneg_enable & i_lvl.aneg_done))
        else $error("Negotiation complete bit wrong");
    a_live_mirror: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        1'b1 |=> o_status[3:0] == $past({i_lvl.sig_detect, i_lvl.jabber, i_lvl.remote_fault, i_lvl.link_ok}))
        else $error("Mirrored bits wrong");

    // Run of Idles: a gap keeps it, any other symbol or leaving the packet ends it
    a_prem_end_gap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sym_in_pkt && i_rx_sym.idle) ##1 (i_rx_sym.in_packet && !i_rx_sym.sym_valid)
        ##1 (sym_in_pkt && i_rx_sym.idle) |-> ##2 o_status[prs_pkg::PREM_END_BIT])
        else $error("Premature end across a gap not latched");
    a_prem_lone_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sym_in_pkt && !i_rx_sym.idle) ##1 (sym_in_pkt && i_rx_sym.idle)
        |-> !prem_end)
        else $error("Single Idle taken as premature end");
    a_idle_run_end: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_rx_sym.in_packet
        |=> idle_cnt == prs_pkg::IDLE_RST)
        else $error("Idle run survived the end of the packet");

    // Receive error toward the MAC only for bad or Halt symbols in 100Base mode
    a_rx_err_quiet: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !(sym_in_pkt && (i_rx_sym.invalid || i_rx_sym.halt))
        |=> !o_rx_err)
        else $error("Receive error without a bad symbol");
    a_rx_err_ten: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_lvl.mode_100
        |=> !o_rx_err)
        else $error("Receive error in 10Base-T mode");

    // Negotiation complete stays low while disabled or still running
    a_aneg_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_lvl.aneg_enable
        |=> !o_status[prs_pkg::ANEG_DONE_BIT])
        else $error("Negotiation complete while disabled");
    a_aneg_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_lvl.aneg_done
        |=> !o_status[prs_pkg::ANEG_DONE_BIT])
        else $error("Negotiation complete while in progress");

    // Reset empties the whole image; no disable here, or the check could never run
    a_status_reset: assert property (@(posedge i_mclk)
        !i_rst_n
        |=> (o_status == prs_pkg::STATUS_RST) && !o_rx_err)
        else $error("Register image not cleared by reset");

    c_prem_end: cover property (@(posedge i_mclk) disable iff (!i_rst_n) prem_end);
    c_set_on_rd: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_rd_strobe && (ev_set != '0));
    c_halt_err: cover property (@(posedge i_mclk) disable iff (!i_rst_n) sym_in_pkt && i_rx_sym.halt);
    c_aneg_done: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_status[prs_pkg::ANEG_DONE_BIT]));
    c_rd_clear: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_rd_strobe && (ev_q != '0));

endmodule

// file: tb/prs_sta_model.sv
// Management entity model: issues register reads and returns the image seen
`timescale 1ns/100ps

module prs_sta_model (
    input  wire logic        i_mclk,
    input  wire logic        i_req,
    input  wire logic [15:0] i_status,
    output logic             o_rd_strobe,
    output logic [15:0]      o_rd_data,
    output logic             o_rd_valid
);
    // Strobe follows the request, so a read lasts as long as the request is held
    assign o_rd_strobe = i_req;
    // Capture at the read edge; outside a read the data lines toggle the last value every edge
    always_ff @(posedge i_mclk) begin
        o_rd_valid <= i_req;
        if (i_req) begin
            o_rd_data <= i_status;
        end else begin
            o_rd_data <= ~o_rd_data;  // Toggles so a stale value never looks valid
        end
    end
endmodule

// file: tb/tb_phy_100tx_receive_status_bits.sv
// Testbench for the receive status bits: event latches, read clear and live mirrors
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin $display("wrong value %s expected %h seen %h", nm, ex, got); n_mismatch++; end end

module tb_phy_100tx_receive_status_bits;
    logic                  i_mclk     = 1'b0;
    logic                  i_rst_n    = 1'b0;
    prs_pkg::prs_rx_sym_t  i_rx_sym   = 6'h00;
    prs_pkg::prs_phy_lvl_t i_lvl      = 8'hd1;
    logic                  rd_req     = 1'b0;
    logic                  rd_strobe;
    logic [15:0]           o_status;
    logic                  o_rx_err;
    logic [15:0]           rd_data;
    logic                  rd_valid;
    logic [15:0]           exp_q[$];
    logic [15:0]           exp_rd;
    logic [15:0]           rnd        = 16'h042a;
    logic [7:0]            rl;
    int                    n_mismatch = 0;
    int                    checks     = 0;
    int                    cycles     = 0;
    // Event table: symbol, levels, cycles held, status bit, receive error expected
    logic [5:0]  ev_sym[6] = '{6'h38, 6'h34, 6'h01, 6'h00, 6'h00, 6'h32};
    logic [7:0]  ev_lvl[6] = '{8'hd1, 8'hd1, 8'hd1, 8'hf1, 8'h91, 8'hd1};
    int          ev_len[6] = '{1, 1, 1, 1, 1, 2};
    int unsigned ev_bit[6] = '{prs_pkg::INV_SYM_BIT, prs_pkg::HALT_BIT, prs_pkg::FALSE_CAR_BIT,
                               prs_pkg::PLL_ERR_BIT, prs_pkg::SIG_LOST_BIT, prs_pkg::PREM_END_BIT};
    logic        ev_err[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    prs_rx_status i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rx_sym(i_rx_sym), .i_lvl(i_lvl),
                         .i_rd_strobe(rd_strobe), .o_status(o_status), .o_rx_err(o_rx_err));
    prs_sta_model i_sta (.i_mclk(i_mclk), .i_req(rd_req), .i_status(o_status),
                         .o_rd_strobe(rd_strobe), .o_rd_data(rd_data), .o_rd_valid(rd_valid));

    // ======================================================================
    // Helpers
    function automatic logic [15:0] live(prs_pkg::prs_phy_lvl_t l);
        logic [15:0] e;
        e = 16'h0000;
        e[prs_pkg::ANEG_DONE_BIT] = l.aneg_enable & l.aneg_done;
        e[prs_pkg::SIG_DET_BIT]   = l.sig_detect;
        e[prs_pkg::JABBER_BIT]    = l.jabber;
        e[prs_pkg::RFAULT_BIT]    = l.remote_fault;
        e[prs_pkg::LINK_BIT]      = l.link_ok;
        return e;
    endfunction

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // One cycle of stimulus; a read notes its expected image first
    task automatic cyc(logic [5:0] s, logic [7:0] l, logic rd, logic [15:0] ex);
        i_rx_sym = prs_pkg::prs_rx_sym_t'(s);
        i_lvl    = prs_pkg::prs_phy_lvl_t'(l);
        rd_req   = rd;
        if (rd) exp_q.push_back(ex);
        @(posedge i_mclk);
        #2;
    endtask

    task automatic complete_run;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ======================================================================
    // Clock, watchdog and read monitor
    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    // Ceiling is several times the planned run, so only a hang reaches it
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 1000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Oldest note is matched against each returned read
    always @(negedge i_mclk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                exp_rd = exp_q.pop_front();
                `CHK("register read", exp_rd, rd_data)
            end else begin
                `CHK("unexpected read", 1'b0, 1'b1)
            end
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge i_mclk);
        #2;
        `CHK("status in reset", 16'h0000, o_status)
        i_rst_n = 1'b1;
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        // Each event latches, holds across idle, then a read clears it
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < ev_len[k]; j++) cyc(ev_sym[k], ev_lvl[k], 1'b0, 16'h0000);
            `CHK("receive error", ev_err[k], o_rx_err)
            repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
            cyc(6'h00, 8'hd1, 1'b1, live(8'hd1) | (16'h0001 << ev_bit[k]));
            repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
            cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
            repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        end
        // Event in the very cycle of a read must survive for the next read
        cyc(6'h38, 8'hd1, 1'b1, live(8'hd1));
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1) | 16'h0080);
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
        // Idle run: a data symbol breaks it, a cycle with no symbol does not
        cyc(6'h32, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h30, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h32, 8'hd1, 1'b0, 16'h0000);
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
        cyc(6'h32, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h10, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h32, 8'hd1, 1'b0, 16'h0000);
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1) | 16'h0020);
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
        // 10Base-T: errors and lost signal latch nothing
        cyc(6'h38, 8'h51, 1'b0, 16'h0000);
        `CHK("receive error 10 mode", 1'b0, o_rx_err)
        cyc(6'h00, 8'h11, 1'b0, 16'h0000);
        repeat (3) cyc(6'h00, 8'h51, 1'b0, 16'h0000);
        cyc(6'h00, 8'h51, 1'b1, live(8'h51));
        // Random live levels, 10 mode kept so no event can latch
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            rl  = {1'b0, rnd[6:0]};
            repeat (2) cyc(6'h00, rl, 1'b0, 16'h0000);
            cyc(6'h00, rl, 1'b1, live(rl));
        end
        // Reset in mid-run clears a pending event as a read would
        cyc(6'h38, 8'hd1, 1'b0, 16'h0000);
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        i_rst_n = 1'b0;
        cyc(6'h38, 8'hd1, 1'b0, 16'h0000);
        `CHK("receive error in reset", 1'b0, o_rx_err)
        cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        `CHK("status in reset", 16'h0000, o_status)
        i_rst_n = 1'b1;
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        cyc(6'h00, 8'hd1, 1'b1, live(8'hd1));
        repeat (3) cyc(6'h00, 8'hd1, 1'b0, 16'h0000);
        `CHK("pending reads", 0, exp_q.size())
        complete_run();
    end
endmodule
